// [common/mmr_pkg.sv]
package mmr_pkg;

  // clock and serial timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int BIT_TIME_NS     = 32000;
  localparam int BIT_CYCLES      = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int HALF_CYCLES     = BIT_CYCLES / 2;
  localparam int MARKER_PERIOD_MS = 500;
  localparam int MARKER_CYCLES   = MARKER_PERIOD_MS * (1000000 / CLK_PERIOD_NS);

  // register map (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SA_BIT     = 1;
  localparam logic RST_ENABLE    = 1'b0;
  localparam logic RST_SA        = 1'b0;

  // plain note functions, channel 1
  localparam logic [6:0] NOTE_LEVEL_REDUCE  = 7'h5D;
  localparam logic [6:0] NOTE_SUM_SINGLE    = 7'h2A;
  localparam logic [6:0] NOTE_INTERCOM      = 7'h5E;
  localparam logic [6:0] NOTE_SCENE_RESTORE = 7'h5F;
  localparam logic [6:0] NOTE_ALT_PAIR      = 7'h32;
  localparam logic [6:0] NOTE_ALT_FIRST     = 7'h3E;
  localparam logic [6:0] NOTE_ALT_LAST      = 7'h42;
  localparam logic [6:0] NOTE_SCENE_FIRST   = 7'h36;
  localparam logic [6:0] NOTE_SCENE_LAST    = 7'h3D;
  localparam logic [6:0] NOTE_GAIN_LINK     = 7'h2D;
  localparam logic [6:0] NOTE_SILENCE       = 7'h2C;
  localparam logic [6:0] NOTE_ISOLATE       = 7'h2B;

  // control-surface notes and the V-Pot control change, channel 1
  localparam logic [6:0] NOTE_ARM_FIRST     = 7'h00;
  localparam logic [6:0] NOTE_MUTE_FIRST    = 7'h10;
  localparam logic [6:0] NOTE_SELECT_FIRST  = 7'h18;
  localparam logic [6:0] NOTE_VPOT_FIRST    = 7'h20;
  localparam logic [6:0] NOTE_PROCESSING    = 7'h29;
  localparam logic [6:0] NOTE_BANK_LEFT     = 7'h2E;
  localparam logic [6:0] NOTE_BANK_RIGHT    = 7'h2F;
  localparam logic [6:0] NOTE_CHAN_LEFT     = 7'h30;
  localparam logic [6:0] NOTE_CHAN_RIGHT    = 7'h31;
  localparam logic [6:0] NOTE_ROW_UP        = 7'h60;
  localparam logic [6:0] NOTE_ROW_DOWN      = 7'h61;
  localparam logic [6:0] CC_VPOT_FIRST      = 7'h10;

  // control change map
  localparam logic [6:0] CC_VOLUME          = 7'h07;
  localparam logic [6:0] CC_FADER_FIRST     = 7'h66;
  localparam logic [6:0] CC_FADER_LAST      = 7'h75;
  localparam logic [3:0] CH_FUNC            = 4'hC;
  localparam logic [6:0] CC_GAIN_LINK       = 7'h66;
  localparam logic [6:0] CC_BUS_FIRST       = 7'h68;
  localparam logic [6:0] CC_BUS_LAST        = 7'h75;

  // fader values and window limits
  localparam logic [6:0] FADER_MIN          = 7'h00;
  localparam logic [6:0] FADER_UNITY        = 7'h68;
  localparam logic [6:0] FADER_MAX          = 7'h7F;
  localparam logic [5:0] WIN_CHAN_MAX       = 6'h38;
  localparam logic [1:0] ROW_LAST           = 2'h2;

  // loopback marker message
  localparam logic [7:0] MARKER_STATUS      = 8'h9F;
  localparam logic [7:0] MARKER_NOTE        = 8'h7E;
  localparam logic [7:0] MARKER_VEL         = 8'h7F;

  typedef enum logic [4:0] {
    EV_NONE, EV_MAIN_VOL, EV_FADER, EV_PAN, EV_PAN_CENTER, EV_UNITY, EV_MUTE,
    EV_SELECT, EV_LEVEL_REDUCE, EV_SUM_SINGLE, EV_INTERCOM, EV_SCENE_RESTORE,
    EV_ALT_PAIR, EV_ALT_LISTEN, EV_SCENE_LOAD, EV_GAIN_LINK, EV_SILENCE,
    EV_ISOLATE, EV_BUS_SELECT
  } mmr_kind_t;

  typedef struct packed {
    logic       valid;
    mmr_kind_t  kind;
    logic [1:0] row;
    logic [5:0] index;
    logic [6:0] value;
  } mmr_event_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] d1;
    logic [7:0] d2;
  } mmr_msg_t;

endpackage : mmr_pkg

// [src/mmr_remote_control.sv]
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mmr_remote_control
  import mmr_pkg::*;
#(
  parameter int MARKER_PERIOD = MARKER_CYCLES,
  parameter int BIT_PERIOD    = BIT_CYCLES
) (
  // clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // midi link
  input  wire logic        midi_rx_i,
  output logic             midi_tx_o,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // mixer side
  output mmr_event_t       event_o,
  output logic             remote_enable_o,
  output logic             standalone_o,
  output logic             gain_link_o,
  output logic [2:0]       dest_bus_o,
  output logic [1:0]       win_row_o,
  output logic [5:0]       win_chan_o
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mmr_rx_state_t;

  // input synchroniser and filtered line
  logic        sync1_reg, sync2_reg, sync3_reg, line_reg;
  // receiver
  mmr_rx_state_t rx_state_reg;
  logic [11:0] rx_cnt_reg;
  logic [2:0]  rx_bit_reg;
  logic [7:0]  rx_shift_reg;
  logic        rx_vld_reg;
  logic [7:0]  rx_byte_reg;
  // parser
  logic [7:0]  run_status_reg;
  logic [7:0]  data1_reg;
  logic        have1_reg;
  logic        msg_vld_reg;
  mmr_msg_t    msg_reg;
  // control state
  logic        enable_reg, sa_reg, loop_seen_reg, proc_held_reg, gain_link_reg;
  logic [2:0]  dest_bus_reg;
  logic [1:0]  win_row_reg;
  logic [5:0]  win_chan_reg;
  mmr_event_t  ev_reg, ev_next;
  logic [31:0] rdata_reg;
  // transmitter
  logic [25:0] mark_cnt_reg;
  logic        mark_due_reg;
  logic [23:0] tx_msg_reg;
  logic [1:0]  tx_left_reg;
  logic [9:0]  tx_shift_reg;
  logic [3:0]  tx_bit_reg;
  logic [11:0] tx_cnt_reg;
  logic        tx_line_reg;

  // ---------------- serial receive ----------------
  wire rx_stable   = (sync2_reg == sync3_reg);
  wire rx_bit_end  = (rx_cnt_reg == 12'(BIT_PERIOD - 1));
  wire rx_half_end = (rx_cnt_reg == 12'(BIT_PERIOD / 2 - 1));

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      line_reg  <= 1'b1;
    end else if (ce_i) begin
      sync1_reg <= midi_rx_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (rx_stable) begin
        line_reg <= sync3_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg   <= 12'h000;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_vld_reg   <= 1'b0;
      rx_byte_reg  <= 8'h00;
    end else if (ce_i) begin
      rx_vld_reg <= 1'b0;
      rx_cnt_reg <= rx_cnt_reg + 12'h001;
      unique case (rx_state_reg)
        RX_IDLE: begin
          rx_cnt_reg <= 12'h000;
          if (!line_reg) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (rx_half_end) begin
            rx_cnt_reg   <= 12'h000;
            rx_bit_reg   <= 3'h0;
            rx_state_reg <= line_reg ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_cnt_reg   <= 12'h000;
            rx_shift_reg <= {line_reg, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_bit_end) begin
            rx_state_reg <= RX_IDLE;
            rx_vld_reg   <= line_reg;
            rx_byte_reg  <= rx_shift_reg;
          end
        end
      endcase
    end
  end

  // ---------------- message framing ----------------
  wire is_realtime = (rx_byte_reg[7:3] == 5'h1F);
  wire two_data    = (run_status_reg[7:4] != 4'hC) && (run_status_reg[7:4] != 4'hD);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_status_reg <= 8'h00;
      data1_reg      <= 8'h00;
      have1_reg      <= 1'b0;
      msg_vld_reg    <= 1'b0;
      msg_reg        <= '0;
    end else if (ce_i) begin
      msg_vld_reg <= 1'b0;
      if (rx_vld_reg && !is_realtime) begin
        if (rx_byte_reg[7]) begin
          run_status_reg <= (rx_byte_reg[7:4] == 4'hF) ? 8'h00 : rx_byte_reg;
          have1_reg      <= 1'b0;
        end else if (run_status_reg[7] && two_data) begin
          if (!have1_reg) begin
            data1_reg <= rx_byte_reg;
            have1_reg <= 1'b1;
          end else begin
            have1_reg   <= 1'b0;
            msg_vld_reg <= 1'b1;
            msg_reg     <= '{status: run_status_reg, d1: data1_reg, d2: rx_byte_reg};
          end
        end
      end
    end
  end

  // ---------------- message decode ----------------
  wire [3:0] st_kind = msg_reg.status[7:4];
  wire [3:0] st_chan = msg_reg.status[3:0];
  wire [6:0] d1      = msg_reg.d1[6:0];
  wire [6:0] d2      = msg_reg.d2[6:0];
  wire       full    = enable_reg;
  wire       sa_only = sa_reg && !enable_reg;
  wire       active  = enable_reg || sa_reg;
  wire       is_on   = (st_kind == 4'h9) && (d2 != 7'h00);
  wire       is_note = (st_kind == 4'h8) || (st_kind == 4'h9);
  wire       ch1     = (st_chan == 4'h0);
  wire       note1   = is_note && ch1;
  wire       press1  = is_on && ch1;
  wire       is_cc   = (st_kind == 4'hB);
  wire       is_pb   = (st_kind == 4'hE) && (st_chan[3] == 1'b0);
  wire       marker_hit = (msg_reg.status == MARKER_STATUS) && (msg_reg.d1 == MARKER_NOTE);

  wire       alt_hit   = (d1 >= NOTE_ALT_FIRST) && (d1 <= NOTE_ALT_LAST);
  wire       scene_hit = (d1 >= NOTE_SCENE_FIRST) && (d1 <= NOTE_SCENE_LAST);
  wire       arm_hit   = (d1[6:3] == NOTE_ARM_FIRST[6:3]);
  wire       mute_hit  = (d1[6:3] == NOTE_MUTE_FIRST[6:3]);
  wire       sel_hit   = (d1[6:3] == NOTE_SELECT_FIRST[6:3]);
  wire       vpush_hit = (d1[6:3] == NOTE_VPOT_FIRST[6:3]);
  wire       nav_hit   = (d1 == NOTE_CHAN_LEFT) || (d1 == NOTE_CHAN_RIGHT) ||
                         (d1 == NOTE_BANK_LEFT) || (d1 == NOTE_BANK_RIGHT) ||
                         (d1 == NOTE_ROW_UP) || (d1 == NOTE_ROW_DOWN);
  wire       surf_note = note1 && (arm_hit || mute_hit || sel_hit || vpush_hit || nav_hit ||
                         (d1 == NOTE_PROCESSING));
  wire       vpot_cc   = is_cc && ch1 && (d1[6:3] == CC_VPOT_FIRST[6:3]);
  wire       surf_msg  = surf_note || vpot_cc || is_pb;

  wire       fad_hit   = is_cc && (st_chan < CH_FUNC) &&
                         (d1 >= CC_FADER_FIRST) && (d1 <= CC_FADER_LAST);
  wire [1:0] fad_row   = st_chan[3:2];
  wire [3:0] fad_off   = 4'(d1 - CC_FADER_FIRST);
  wire       fad_ok    = fad_hit && (full || (sa_only && fad_row != 2'h1));
  wire       func_cc   = is_cc && (st_chan == CH_FUNC) && full;
  wire       bus_hit   = func_cc && (d1 >= CC_BUS_FIRST) && (d1 <= CC_BUS_LAST);
  wire [2:0] bus_idx   = 3'((d1 - CC_BUS_FIRST) >> 1);
  wire [5:0] pb_chan   = win_chan_reg + {3'h0, st_chan[2:0]};

  // one event per message; anything unmatched leaves EV_NONE
  always_comb begin
    ev_next = '{valid: 1'b0, kind: EV_NONE, row: 2'h0, index: 6'h00, value: d2};
    if (msg_vld_reg && active && !marker_hit) begin
      if (is_cc && ch1 && d1 == CC_VOLUME) begin
        ev_next.kind = EV_MAIN_VOL;
      end else if (fad_ok) begin
        ev_next.kind  = EV_FADER;
        ev_next.row   = fad_row;
        ev_next.index = {st_chan[1:0], fad_off};
      end else if (func_cc && d1 == CC_GAIN_LINK) begin
        ev_next.kind = EV_GAIN_LINK;
      end else if (bus_hit) begin
        ev_next.kind  = EV_BUS_SELECT;
        ev_next.index = {3'h0, bus_idx};
      end else if (vpot_cc) begin
        ev_next.kind  = EV_PAN;
        ev_next.row   = win_row_reg;
        ev_next.index = win_chan_reg + {3'h0, d1[2:0]};
      end else if (is_pb && !(sa_only && win_row_reg == 2'h1)) begin
        ev_next.kind  = EV_FADER;
        ev_next.row   = win_row_reg;
        ev_next.index = pb_chan;
      end else if (press1 && arm_hit) begin
        ev_next.kind  = EV_BUS_SELECT;
        ev_next.index = {3'h0, d1[2:0]};
      end else if (press1 && mute_hit) begin
        ev_next.kind  = EV_MUTE;
        ev_next.row   = win_row_reg;
        ev_next.index = win_chan_reg + {3'h0, d1[2:0]};
      end else if (press1 && sel_hit) begin
        ev_next.kind  = proc_held_reg ? EV_UNITY : EV_SELECT;
        ev_next.value = proc_held_reg ? FADER_UNITY : d2;
        ev_next.row   = win_row_reg;
        ev_next.index = win_chan_reg + {3'h0, d1[2:0]};
      end else if (press1 && vpush_hit) begin
        ev_next.kind  = EV_PAN_CENTER;
        ev_next.row   = win_row_reg;
        ev_next.index = win_chan_reg + {3'h0, d1[2:0]};
      end else if (note1 && d1 == NOTE_SILENCE && (full || sa_only)) begin
        ev_next.kind = EV_SILENCE;
      end else if (note1 && full) begin
        if (d1 == NOTE_LEVEL_REDUCE) begin
          ev_next.kind = EV_LEVEL_REDUCE;
        end else if (d1 == NOTE_SUM_SINGLE) begin
          ev_next.kind = EV_SUM_SINGLE;
        end else if (d1 == NOTE_INTERCOM) begin
          ev_next.kind = EV_INTERCOM;
        end else if (d1 == NOTE_SCENE_RESTORE) begin
          ev_next.kind = EV_SCENE_RESTORE;
        end else if (d1 == NOTE_ALT_PAIR) begin
          ev_next.kind = EV_ALT_PAIR;
        end else if (d1 == NOTE_GAIN_LINK) begin
          ev_next.kind = EV_GAIN_LINK;
        end else if (d1 == NOTE_ISOLATE) begin
          ev_next.kind = EV_ISOLATE;
        end else if (alt_hit) begin
          ev_next.kind  = EV_ALT_LISTEN;
          ev_next.index = 6'(d1 - NOTE_ALT_FIRST);
        end else if (scene_hit && is_on) begin
          ev_next.kind  = EV_SCENE_LOAD;
          ev_next.index = 6'(d1 - NOTE_SCENE_FIRST);
        end
      end
    end
    ev_next.valid = (ev_next.kind != EV_NONE);
  end

  // ---------------- window navigation ----------------
  wire nav_go = msg_vld_reg && active && press1 && nav_hit;
  wire [5:0] chan_l  = (win_chan_reg == 6'h00) ? 6'h00 : win_chan_reg - 6'h01;
  wire [5:0] chan_r  = (win_chan_reg >= WIN_CHAN_MAX) ? WIN_CHAN_MAX : win_chan_reg + 6'h01;
  wire [5:0] bank_l  = (win_chan_reg < 6'h08) ? 6'h00 : win_chan_reg - 6'h08;
  wire [5:0] bank_r  = (win_chan_reg >= WIN_CHAN_MAX - 6'h08) ? WIN_CHAN_MAX :
                       win_chan_reg + 6'h08;
  wire [1:0] row_up  = (win_row_reg == 2'h0) ? 2'h0 :
                       (sa_only && win_row_reg == ROW_LAST) ? 2'h0 : win_row_reg - 2'h1;
  wire [1:0] row_dn  = (win_row_reg == ROW_LAST) ? ROW_LAST :
                       (sa_only && win_row_reg == 2'h0) ? ROW_LAST : win_row_reg + 2'h1;
  wire [5:0] chan_nx = (d1 == NOTE_CHAN_LEFT)  ? chan_l :
                       (d1 == NOTE_CHAN_RIGHT) ? chan_r :
                       (d1 == NOTE_BANK_LEFT)  ? bank_l :
                       (d1 == NOTE_BANK_RIGHT) ? bank_r : win_chan_reg;
  wire [1:0] row_nx  = (d1 == NOTE_ROW_UP)   ? row_up :
                       (d1 == NOTE_ROW_DOWN) ? row_dn : win_row_reg;

  // ---------------- control and mixer state ----------------
  wire       ctrl_wr   = reg_wr_i && (reg_addr_i == REG_CTRL);
  wire       wr_en_bit = reg_wdata_i[CTRL_ENABLE_BIT];
  wire       wr_sa_bit = reg_wdata_i[CTRL_SA_BIT];
  wire       loop_hit  = msg_vld_reg && marker_hit && enable_reg;
  wire       sa_set    = ctrl_wr && wr_sa_bit && enable_reg;
  wire       sa_clr    = ctrl_wr && !wr_sa_bit && !enable_reg;
  wire       gl_toggle = ev_next.valid && ev_next.kind == EV_GAIN_LINK;
  wire       bus_sel   = ev_next.valid && ev_next.kind == EV_BUS_SELECT;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      enable_reg    <= RST_ENABLE;
      sa_reg        <= RST_SA;
      loop_seen_reg <= 1'b0;
      proc_held_reg <= 1'b0;
      gain_link_reg <= 1'b0;
      dest_bus_reg  <= 3'h0;
      win_row_reg   <= 2'h0;
      win_chan_reg  <= 6'h00;
      ev_reg        <= '0;
    end else if (ce_i) begin
      ev_reg <= ev_next;
      if (loop_hit) begin
        enable_reg <= 1'b0;
      end else if (ctrl_wr) begin
        enable_reg <= wr_en_bit;
      end
      if (loop_hit) begin
        loop_seen_reg <= 1'b1;
      end else if (ctrl_wr && wr_en_bit) begin
        loop_seen_reg <= 1'b0;
      end
      if (sa_set) begin
        sa_reg <= 1'b1;
      end else if (sa_clr) begin
        sa_reg <= 1'b0;
      end
      if (msg_vld_reg && active && note1 && d1 == NOTE_PROCESSING) begin
        proc_held_reg <= is_on;
      end
      if (bus_sel) begin
        gain_link_reg <= 1'b0;
        dest_bus_reg  <= ev_next.index[2:0];
      end else if (gl_toggle) begin
        gain_link_reg <= !gain_link_reg;
      end
      if (nav_go) begin
        win_chan_reg <= chan_nx;
        win_row_reg  <= row_nx;
      end
    end
  end

  // ---------------- register read ----------------
  wire [31:0] ctrl_view   = {30'h0, sa_reg, enable_reg};
  wire [31:0] status_view = {18'h0, loop_seen_reg, proc_held_reg, gain_link_reg,
                             dest_bus_reg, win_row_reg, win_chan_reg};
  wire [31:0] rd_sel      = (reg_addr_i == REG_CTRL)   ? ctrl_view :
                            (reg_addr_i == REG_STATUS) ? status_view : 32'h0000_0000;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_reg <= reg_rd_i ? rd_sel : 32'h0000_0000;
    end
  end

  // ---------------- transmit: echo and loopback marker ----------------
  // only surface messages are echoed; nothing is sent on its own after reset until enable is set
  wire tx_bit_end = (tx_cnt_reg == 12'(BIT_PERIOD - 1));
  wire tx_idle    = (tx_bit_reg == 4'h0);
  wire seq_free   = (tx_left_reg == 2'h0);
  wire echo_req   = msg_vld_reg && active && surf_msg && !marker_hit;
  wire mark_tick  = (mark_cnt_reg == 26'(MARKER_PERIOD - 1));

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mark_cnt_reg <= 26'h0000000;
      mark_due_reg <= 1'b0;
    end else if (ce_i) begin
      mark_cnt_reg <= (mark_tick || !enable_reg) ? 26'h0000000 : mark_cnt_reg + 26'h0000001;
      if (mark_tick && enable_reg) begin
        mark_due_reg <= 1'b1;
      end else if (seq_free && !echo_req) begin
        mark_due_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_msg_reg   <= 24'h000000;
      tx_left_reg  <= 2'h0;
      tx_shift_reg <= 10'h3FF;
      tx_bit_reg   <= 4'h0;
      tx_cnt_reg   <= 12'h000;
      tx_line_reg  <= 1'b1;
    end else if (ce_i) begin
      if (seq_free && echo_req) begin
        tx_msg_reg  <= msg_reg;
        tx_left_reg <= 2'h3;
      end else if (seq_free && mark_due_reg) begin
        tx_msg_reg  <= {MARKER_STATUS, MARKER_NOTE, MARKER_VEL};
        tx_left_reg <= 2'h3;
      end else if (tx_idle && !seq_free) begin
        tx_shift_reg <= {1'b1, tx_msg_reg[23:16], 1'b0};
        tx_msg_reg   <= {tx_msg_reg[15:0], 8'h00};
        tx_left_reg  <= tx_left_reg - 2'h1;
        tx_bit_reg   <= 4'hA;
        tx_cnt_reg   <= 12'h000;
      end
      if (!tx_idle) begin
        tx_line_reg <= tx_shift_reg[0];
        tx_cnt_reg  <= tx_bit_end ? 12'h000 : tx_cnt_reg + 12'h001;
        if (tx_bit_end) begin
          tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
          tx_bit_reg   <= tx_bit_reg - 4'h1;
        end
      end else begin
        tx_line_reg <= 1'b1;
      end
    end
  end

  assign midi_tx_o       = tx_line_reg;
  assign reg_rdata_o     = rdata_reg;
  assign event_o         = ev_reg;
  assign remote_enable_o = enable_reg;
  assign standalone_o    = sa_reg;
  assign gain_link_o     = gain_link_reg;
  assign dest_bus_o      = dest_bus_reg;
  assign win_row_o       = win_row_reg;
  assign win_chan_o      = win_chan_reg;

endmodule : mmr_remote_control
`default_nettype wire

// [verif/mmr_midi_src.sv]
`timescale 1ns/1ps
`default_nettype none
module mmr_midi_src
  import mmr_pkg::*;
#(
  parameter int BIT_PERIOD = BIT_CYCLES
) (
  // serial link
  input  wire logic clk_i,
  output logic      line_o
);
  initial line_o = 1'b1;
  // start, data lsb first, stop; idles high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (BIT_PERIOD - 1) @(posedge clk_i);
    end
  endtask : send
endmodule : mmr_midi_src
`default_nettype wire

// [verif/mmr_remote_control_props.sv]
`timescale 1ns/1ps
`default_nettype none
module mmr_remote_control_props
  import mmr_pkg::*;
(
  // watched ports
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire mmr_event_t  event_o,
  input wire logic        remote_enable_o,
  input wire logic        standalone_o,
  input wire logic        gain_link_o,
  input wire logic [1:0]  win_row_o,
  input wire logic [5:0]  win_chan_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire ev = event_o.valid;
  a_sa_on: assert property ($rose(standalone_o) |-> $past(remote_enable_o))
    else $error("standalone set while disabled");
  a_sa_off: assert property ($fell(standalone_o) |-> !$past(remote_enable_o))
    else $error("standalone cleared while enabled");
  a_event_pulse: assert property (ev |=> !ev)
    else $error("event longer than one cycle");
  a_unity_value: assert property (ev && event_o.kind == EV_UNITY
    |-> event_o.value == FADER_UNITY) else $error("unity value wrong");
  a_bus_unlink: assert property (ev && event_o.kind == EV_BUS_SELECT
    |-> ##[0:2] !gain_link_o) else $error("gain link kept");
  a_win_bound: assert property (win_row_o <= ROW_LAST && win_chan_o <= WIN_CHAN_MAX)
    else $error("window out of range");
  a_row_skip: assert property (ev && standalone_o && !remote_enable_o
    && event_o.kind == EV_FADER |-> event_o.row != 2'h1) else $error("row skipped");
  a_scene_idx: assert property (ev && event_o.kind == EV_SCENE_LOAD
    |-> event_o.index < 6'h08) else $error("scene index");
endmodule : mmr_remote_control_props
bind mmr_remote_control mmr_remote_control_props props_u (.ref_clk_i, .sys_rst_i,
  .event_o, .remote_enable_o, .standalone_o, .gain_link_o, .win_row_o, .win_chan_o);
`default_nettype wire

// [verif/mmr_remote_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mmr_remote_control_tb;
  import mmr_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  localparam int BITP = 32;
  logic        rx, wr = 1'b0, rd = 1'b0, ce = 1'b1, en, sa, gl, tx;
  logic [7:0]  txb;
  logic [23:0] txh = '0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [2:0]  bus;
  logic [1:0]  row;
  logic [5:0]  chan;
  logic [6:0]  v;
  mmr_event_t  ev, ev_q = '0;
  int mismatches = 0, n_tests = 0, cyc = 0, seed = 32'h63d9, n_tx = 0, n_mark = 0, n0;
  mmr_midi_src #(.BIT_PERIOD(BITP)) src_u (.clk_i(ref_clk_i), .line_o(rx));
  mmr_remote_control #(.MARKER_PERIOD(2000), .BIT_PERIOD(BITP)) dut_u (.ref_clk_i, .sys_rst_i,
    .ce_i(ce),
    .midi_rx_i(rx), .midi_tx_o(tx), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .event_o(ev), .remote_enable_o(en),
    .standalone_o(sa), .gain_link_o(gl), .dest_bus_o(bus), .win_row_o(row), .win_chan_o(chan));
  always #5 ref_clk_i = ~ref_clk_i;
  // far-side receiver: keeps the last three bytes sent by the block
  always begin : tx_mon
    @(negedge tx);
    repeat (BITP + BITP / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      txb = {tx, txb[7:1]};
      repeat (BITP) @(posedge ref_clk_i);
    end
    txh = {txh[15:0], txb};
    n_tx++;
    if (txh == {MARKER_STATUS, MARKER_NOTE, MARKER_VEL}) n_mark++;
  end
  always @(posedge ref_clk_i) begin
    if (ev.valid === 1'b1) ev_q <= ev;
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      results();
    end
  end
  task results;
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task wr_reg(input logic [3:0] a, input logic [31:0] dt);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, output logic [31:0] dt);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 dt = rdata;
  endtask : rd_reg
  task msg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    src_u.send(a);
    src_u.send(b);
    src_u.send(c);
  endtask : msg
  // expected fader event: row from channel group, index within row
  function automatic mmr_event_t fev(input logic [3:0] ch, input logic [6:0] cc,
                                     input logic [6:0] val);
    fev = '{1'b1, EV_FADER, ch[3:2], 6'({ch[1:0], 4'h0} + (cc - 7'h66)), val};
  endfunction : fev
  // channel 1 note press and the event it should raise
  task nt(input logic [6:0] n, input mmr_kind_t k, input logic [5:0] i);
    msg(8'h90, {1'b0, n}, 8'h7F);
    chk({ev_q.kind, ev_q.index, ev_q.value}, {k, i, 7'h7F});
  endtask : nt
  initial begin
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    wr_reg(REG_CTRL, 32'h2);
    rd_reg(REG_CTRL, d);
    chk(d, 32'h0);
    rd_reg(4'h8, d);
    chk(d, 32'h0);
    ce <= 1'b0;
    wr_reg(REG_CTRL, 32'h1);
    ce <= 1'b1;
    rd_reg(REG_CTRL, d);
    chk(d, 32'h0);
    chk(n_tx, 0);
    wr_reg(REG_CTRL, 32'h1);
    wr_reg(REG_CTRL, 32'h3);
    rd_reg(REG_CTRL, d);
    chk(d, 32'h3);
    v = 7'($random(seed));
    msg(8'hB1, 8'h6A, {1'b0, v});
    chk(32'(ev_q), 32'(fev(4'h1, 7'h6A, v)));
    msg(8'hB9, 8'h75, 8'h7F);
    chk(32'(ev_q), 32'(fev(4'h9, 7'h75, 7'h7F)));
    msg(8'hBD, 8'h66, 8'h40);
    chk(32'(ev_q), 32'(fev(4'h9, 7'h75, 7'h7F)));
    msg(8'hB0, 8'h07, {1'b0, v});
    chk({ev_q.kind, ev_q.value}, {EV_MAIN_VOL, v});
    msg(8'h90, {1'b0, NOTE_LEVEL_REDUCE}, 8'h7F);
    chk({ev_q.kind, ev_q.value}, {EV_LEVEL_REDUCE, 7'h7F});
    nt(7'h40, EV_ALT_LISTEN, 6'h02);
    nt(7'h3D, EV_SCENE_LOAD, 6'h07);
    nt(7'h2C, EV_SILENCE, 6'h00);
    msg(8'hBC, 8'h66, 8'h00);
    chk(gl, 1'b1);
    src_u.send(8'h6A);
    src_u.send(8'h11);
    chk({ev_q.kind, ev_q.index, bus}, {EV_BUS_SELECT, 6'h01, 3'h1});
    chk(gl, 1'b0);
    chk(n_mark != 0, 1'b1);
    msg(MARKER_STATUS, MARKER_NOTE, MARKER_VEL);
    chk(en, 1'b0);
    rd_reg(REG_STATUS, d);
    chk(d[13], 1'b1);
    // let any marker still pending leave the line before the echo check
    repeat (3000) @(posedge ref_clk_i);
    n0 = n_tx;
    msg(8'h90, 8'h03, 8'h7F);
    chk({ev_q.kind, ev_q.index, bus}, {EV_BUS_SELECT, 6'h03, 3'h3});
    repeat (1000) @(posedge ref_clk_i);
    chk(txh, 24'h90037F);
    chk(n_tx - n0, 3);
    msg(8'hB4, 8'h66, 8'h40);
    chk(ev_q.kind, EV_BUS_SELECT);
    msg(8'hB0, 8'h66, 8'h68);
    chk(32'(ev_q), 32'(fev(4'h0, 7'h66, FADER_UNITY)));
    msg(8'h90, 8'h31, 8'h7F);
    msg(8'h90, 8'h2F, 8'h7F);
    msg(8'h90, 8'h61, 8'h7F);
    chk({row, chan}, {2'h2, 6'h09});
    msg(8'h90, 8'h29, 8'h7F);
    msg(8'h90, 8'h19, 8'h7F);
    chk(32'(ev_q), 32'({1'b1, EV_UNITY, 2'h2, 6'h0A, FADER_UNITY}));
    wr_reg(REG_CTRL, 32'h0);
    rd_reg(REG_CTRL, d);
    chk(d, 32'h0);
    results();
  end
endmodule : mmr_remote_control_tb
`default_nettype wire
